// File: verilog/pwt_timer.sv
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pwt_defines.svh"

module pwt_timer #(
    parameter int TICK_CYCLES = `PWT_TICK_NS / `PWT_CLK_NS,
    parameter bit EN_ACTIVE_LOW = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pushbutton_n,
    input wire logic sleep_req,
    input wire logic run_at_powerup,
    output logic power_en,
    output logic power_on_alert_n,
    output logic shutdown_alert_n,
    output logic debounced_button_out_n
);
    import pwt_pkg::*;

    pwt_regs_t r;
    pwt_regs_t next_r;
    pwt_ahb_req_t req;

    assign req = '{hsel: hsel, htrans: htrans, hwrite: hwrite, hsize: hsize,
                   hready: hready, haddr: haddr, hwdata: hwdata};

    function automatic logic [31:0] pwt_read(input logic [7:0] a, input pwt_regs_t s);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            `PWT_OFS_PERIOD: d = {8'h00, s.reg_period};
            `PWT_OFS_RANGE: d = {27'h000_0000, s.reg_range};
            `PWT_OFS_LONG: d = {16'h0000, s.reg_long};
            `PWT_OFS_MAXAWAKE: d = {8'h00, s.reg_max};
            `PWT_OFS_STATUS: d = {24'h00_0000, s.db, s.from_off, s.out_en,
                                  2'b00, s.state};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : pwt_read

    function automatic pwt_regs_t pwt_enter_awake(input pwt_regs_t s);
        pwt_regs_t n;
        n = s;
        n.state = PWT_AWAKE;
        n.phase_cnt = 32'h0000_0000;
        n.period_cnt = 32'h0000_0000;
        n.period_due = 1'b0;
        n.hold_cnt = 16'h0000;
        return n;
    endfunction : pwt_enter_awake

    logic run;
    logic press;
    logic sl_fall;
    logic [31:0] interval;

    always_comb begin
        next_r = r;
        run = (r.state == PWT_AWAKE) || (r.state == PWT_SLEEP);
        press = r.db && !r.db_prev;
        sl_fall = r.sl_prev && !r.sl_s2;
        interval = 32'({8'h00, r.reg_period} << r.reg_range);

        // free-running timebase shared by every timer except the init wait, which counts clocks
        next_r.tick = 1'b0;
        if (r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            next_r.tick_cnt = 16'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.tick_cnt = r.tick_cnt + 16'h0001;
        end

        next_r.pb_s1 = pushbutton_n;
        next_r.pb_s2 = r.pb_s1;
        next_r.sl_s1 = sleep_req;
        next_r.sl_s2 = r.sl_s1;
        next_r.strap_s1 = run_at_powerup;
        next_r.strap_s2 = r.strap_s1;
        next_r.sl_prev = r.sl_s2;
        next_r.db_prev = r.db;

        // copy before any new request below, so a request raised now is kept
        if (r.cfg_req) begin
            next_r.act_period = interval;
            next_r.act_long = r.reg_long;
            next_r.cfg_req = 1'b0;
        end

        // debounce: level must hold for the full window before it is believed
        if (!r.pb_s2 == r.db) begin
            next_r.db_cnt = 6'h00;
        end else if (r.tick) begin
            if (r.db_cnt == `PWT_DB_MS - 6'h01) begin
                next_r.db = !r.pb_s2;
                next_r.db_cnt = 6'h00;
            end else begin
                next_r.db_cnt = r.db_cnt + 6'h01;
            end
        end

        // interval counts through awake and sleep, restarted on each entry into awake
        if (run && r.tick) begin
            if (r.period_cnt + 32'h0000_0001 >= r.act_period) begin
                next_r.period_cnt = 32'h0000_0000;
                next_r.period_due = 1'b1;
            end else begin
                next_r.period_cnt = r.period_cnt + 32'h0000_0001;
            end
        end
        if (run && press) begin
            next_r.period_cnt = 32'h0000_0000;
            next_r.period_due = 1'b0;
        end

        if (run && r.tick) begin
            next_r.phase_cnt = r.phase_cnt + 32'h0000_0001;
            if (r.cfg_cnt == `PWT_CFG_MS - 17'h0_0001) begin
                next_r.cfg_cnt = 17'h0_0000;
                next_r.cfg_req = 1'b1;
            end else begin
                next_r.cfg_cnt = r.cfg_cnt + 17'h0_0001;
            end
            if (r.sl_s2 || r.db) begin
                next_r.hold_cnt = r.hold_cnt + 16'h0001;
            end else begin
                next_r.hold_cnt = 16'h0000;
            end
        end

        unique case (r.state)
            PWT_INIT: begin
                // strap is caught a few clocks after release, past its synchroniser
                next_r.init_cnt = r.init_cnt + 2'h1;
                if (r.init_cnt == `PWT_INIT_WAIT) begin
                    next_r.cfg_req = 1'b1;
                    if (r.strap_s2) begin
                        next_r = pwt_enter_awake(next_r);
                        next_r.from_off = 1'b1;
                    end else begin
                        next_r.state = PWT_OFF;
                    end
                end
            end
            PWT_AWAKE: begin
                if (r.hold_cnt >= r.act_long) begin
                    next_r.state = PWT_SHUT;
                    next_r.phase_cnt = 32'h0000_0000;
                end else if (r.phase_cnt >= `PWT_AWAKE_MIN_MS) begin
                    if (sl_fall || r.phase_cnt >= {8'h00, r.reg_max}) begin
                        next_r.state = PWT_SLEEP;
                        next_r.phase_cnt = 32'h0000_0000;
                        next_r.from_off = 1'b0;
                    end
                end
            end
            PWT_SLEEP: begin
                if (r.hold_cnt >= r.act_long) begin
                    next_r.state = PWT_SHUT;
                    next_r.phase_cnt = 32'h0000_0000;
                end else if (r.phase_cnt >= `PWT_SLEEP_MIN_MS) begin
                    if (r.period_due || r.db || r.sl_s2) begin
                        next_r = pwt_enter_awake(next_r);
                    end
                end
            end
            PWT_SHUT: begin
                if (r.tick) begin
                    next_r.phase_cnt = r.phase_cnt + 32'h0000_0001;
                end
                if (r.phase_cnt >= `PWT_OFF_MS) begin
                    next_r.state = PWT_OFF;
                    next_r.from_off = 1'b0;
                end
            end
            PWT_OFF: begin
                next_r.hold_cnt = 16'h0000;
                next_r.cfg_cnt = 17'h0_0000;
                if (press) begin
                    next_r = pwt_enter_awake(next_r);
                    next_r.from_off = 1'b1;
                    next_r.cfg_req = 1'b1;
                end
            end
            default: next_r.state = PWT_INIT;
        endcase

        // ahb-lite: zero wait states, read data prepared in the address phase
        next_r.hreadyout = 1'b1;
        next_r.bus_wr = req.hsel && req.htrans[1] && req.hready && req.hwrite;
        next_r.bus_addr = req.haddr[7:0];
        next_r.hrdata = 32'h0000_0000;
        if (req.hsel && req.htrans[1] && req.hready && !req.hwrite) begin
            next_r.hrdata = pwt_read(req.haddr[7:0], r);
        end
        if (r.bus_wr) begin
            unique case (r.bus_addr)
                `PWT_OFS_PERIOD: next_r.reg_period = req.hwdata[23:0];
                `PWT_OFS_RANGE: next_r.reg_range = req.hwdata[4:0];
                `PWT_OFS_LONG: next_r.reg_long = req.hwdata[15:0];
                `PWT_OFS_MAXAWAKE: next_r.reg_max = req.hwdata[23:0];
                default: next_r.hreadyout = 1'b1;
            endcase
        end

        next_r.out_en = (next_r.state == PWT_AWAKE) || (next_r.state == PWT_SHUT);
        next_r.alert_on_n = !(next_r.from_off && next_r.out_en);
        next_r.alert_off_n = (next_r.state != PWT_SHUT);
        next_r.pb_out_n = !next_r.db;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.state <= PWT_INIT;
            r.reg_period <= `PWT_RST_PERIOD;
            r.reg_range <= `PWT_RST_RANGE;
            r.reg_long <= `PWT_RST_LONG;
            r.reg_max <= `PWT_RST_MAXAWAKE;
            r.act_period <= {8'h00, `PWT_RST_PERIOD};
            r.act_long <= `PWT_RST_LONG;
            r.hreadyout <= 1'b1;
            r.alert_on_n <= 1'b1;
            r.alert_off_n <= 1'b1;
            r.pb_out_n <= 1'b1;
            // button synchroniser starts at the released level: no phantom press
            r.pb_s1 <= 1'b1;
            r.pb_s2 <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign power_en = r.out_en ^ EN_ACTIVE_LOW;
    assign power_on_alert_n = r.alert_on_n;
    assign shutdown_alert_n = r.alert_off_n;
    assign debounced_button_out_n = r.pb_out_n;

    // grace period expiry followed by the off state
    sequence s_grace_done;
        r.state == PWT_SHUT && r.phase_cnt >= `PWT_OFF_MS;
    endsequence
    sequence s_now_off;
        r.state == PWT_OFF && !r.out_en;
    endsequence

    a_en_follows_state: assert property (@(posedge hclk) disable iff (!hresetn)
        r.out_en == (r.state == PWT_AWAKE || r.state == PWT_SHUT))
        else $error("enable does not match state");
    a_awake_min_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.state == PWT_AWAKE && r.phase_cnt < `PWT_AWAKE_MIN_MS) |=> r.state != PWT_SLEEP)
        else $error("awake left before minimum time");
    a_sleep_min_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.state == PWT_SLEEP && r.phase_cnt < `PWT_SLEEP_MIN_MS) |=> r.state != PWT_AWAKE)
        else $error("woke before minimum sleep");
    a_sleep_on_fall: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.state == PWT_AWAKE && r.phase_cnt >= `PWT_AWAKE_MIN_MS && sl_fall
         && r.hold_cnt < r.act_long) |=> r.state == PWT_SLEEP ##1 !power_en ^ EN_ACTIVE_LOW)
        else $error("sleep request fall not honoured");
    a_grace_alert: assert property (@(posedge hclk) disable iff (!hresetn)
        r.state == PWT_SHUT |-> !shutdown_alert_n && r.out_en)
        else $error("shutdown alert or enable wrong in grace");
    a_grace_to_off: assert property (@(posedge hclk) disable iff (!hresetn)
        s_grace_done |=> s_now_off)
        else $error("grace end did not reach off");
    a_on_alert_held: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.from_off && r.out_en) |-> !power_on_alert_n)
        else $error("power-on alert released early");
    a_press_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        (press && (r.state == PWT_AWAKE || r.state == PWT_SLEEP)) |=> r.period_cnt == 32'h0000_0000)
        else $error("press did not restart interval");
    a_off_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.state == PWT_OFF && press) |=> r.state == PWT_AWAKE && !power_on_alert_n)
        else $error("press in off did not wake with alert");

    // entry into awake seen as a change of state between two edges
    sequence s_awake_entry;
        r.state != PWT_AWAKE ##1 r.state == PWT_AWAKE;
    endsequence

    a_wake_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        s_awake_entry |-> r.period_cnt == 32'h0000_0000 && !r.period_due)
        else $error("interval not restarted on wake");
    a_wake_on_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.state == PWT_SLEEP && r.phase_cnt >= `PWT_SLEEP_MIN_MS && r.hold_cnt < r.act_long
         && (r.period_due || r.db || r.sl_s2)) |=> r.state == PWT_AWAKE && r.out_en)
        else $error("sleep not left on wake cause");
    a_long_hold_shut: assert property (@(posedge hclk) disable iff (!hresetn)
        ((r.state == PWT_AWAKE || r.state == PWT_SLEEP) && r.hold_cnt >= r.act_long)
        |=> r.state == PWT_SHUT && !shutdown_alert_n)
        else $error("long hold did not start shutdown");
    a_off_stays_dark: assert property (@(posedge hclk) disable iff (!hresetn)
        (r.state == PWT_OFF && !press) |=> r.state == PWT_OFF && !r.out_en
        && r.hold_cnt == 16'h0000 && r.cfg_cnt == 17'h0_0000)
        else $error("off state not quiet");
    a_button_echo: assert property (@(posedge hclk) disable iff (!hresetn)
        r.pb_out_n == !r.db)
        else $error("button output does not follow debounce");
    a_db_steady: assert property (@(posedge hclk) disable iff (!hresetn)
        (!r.pb_s2 == r.db) |=> r.db == $past(r.db))
        else $error("debounced level moved without synced change");
    a_cfg_sample: assert property (@(posedge hclk) disable iff (!hresetn)
        r.cfg_req |=> r.act_long == $past(r.reg_long) && r.act_period == $past(interval))
        else $error("configuration not sampled");
    a_alert_off_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
        r.state == PWT_SLEEP |-> power_on_alert_n)
        else $error("power-on alert held while enable off");
endmodule : pwt_timer
`default_nettype wire

// File: verilog/pwt_defines.svh
`ifndef PWT_DEFINES_SVH
`define PWT_DEFINES_SVH
`define PWT_CLK_NS 40
`define PWT_TICK_NS 1000000
`define PWT_AWAKE_MIN_MS 32'h0000_0008
`define PWT_SLEEP_MIN_MS 32'h0000_0080
`define PWT_OFF_MS 32'h0000_03E8
`define PWT_DB_MS 6'h20
`define PWT_CFG_MS 17'h1_01D0
`define PWT_INIT_WAIT 2'h3
`define PWT_OFS_PERIOD 8'h00
`define PWT_OFS_RANGE 8'h04
`define PWT_OFS_LONG 8'h08
`define PWT_OFS_MAXAWAKE 8'h0C
`define PWT_OFS_STATUS 8'h10
`define PWT_RST_PERIOD 24'h00_00FA
`define PWT_RST_RANGE 5'h00
`define PWT_RST_LONG 16'h0080
`define PWT_RST_MAXAWAKE 24'h00_0034
`endif

// File: verilog/pwt_pkg.sv
package pwt_pkg;
    typedef enum logic [2:0] {
        PWT_INIT = 3'b000,
        PWT_OFF = 3'b001,
        PWT_AWAKE = 3'b010,
        PWT_SLEEP = 3'b011,
        PWT_SHUT = 3'b100
    } pwt_state_t;

    typedef struct packed {
        logic hsel;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] haddr;
        logic [31:0] hwdata;
    } pwt_ahb_req_t;

    typedef struct packed {
        pwt_state_t state;
        logic [1:0] init_cnt;
        logic [15:0] tick_cnt;
        logic tick;
        logic pb_s1;
        logic pb_s2;
        logic sl_s1;
        logic sl_s2;
        logic strap_s1;
        logic strap_s2;
        logic sl_prev;
        logic db;
        logic db_prev;
        logic [5:0] db_cnt;
        logic [31:0] period_cnt;
        logic period_due;
        logic [31:0] phase_cnt;
        logic [15:0] hold_cnt;
        logic [16:0] cfg_cnt;
        logic cfg_req;
        logic [31:0] act_period;
        logic [15:0] act_long;
        logic from_off;
        logic [23:0] reg_period;
        logic [4:0] reg_range;
        logic [15:0] reg_long;
        logic [23:0] reg_max;
        logic bus_wr;
        logic [7:0] bus_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic out_en;
        logic alert_on_n;
        logic alert_off_n;
        logic pb_out_n;
    } pwt_regs_t;
endpackage : pwt_pkg

// File: verif/pwt_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pwt_host_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic power_en,
    input wire logic [15:0] fall_clocks,
    input wire logic poke_in_sleep,
    output logic sleep_req
);
    logic en_prev;
    logic [15:0] cnt;
    // poke lands inside minimum sleep but stays far short of the long-hold time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_prev <= 1'b0;
            cnt <= 16'h0000;
            sleep_req <= 1'b0;
        end else begin
            en_prev <= power_en;
            if (power_en != en_prev) begin
                cnt <= 16'h0000;
                if (power_en) begin
                    sleep_req <= (fall_clocks != 16'h0000);
                end
            end else begin
                cnt <= cnt + 16'h0001;
                if (power_en && cnt + 16'h0001 >= fall_clocks) begin
                    sleep_req <= 1'b0;
                end
                if (!power_en && poke_in_sleep && cnt == 16'h012B) begin
                    sleep_req <= 1'b1;
                end
            end
        end
    end
endmodule : pwt_host_model
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwt_defines.svh"
module testbench;
    import pwt_pkg::*;
    typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} pwt_row_t;
    localparam int TK = 32'h0000_0004;
    localparam int SL = 32'h0000_0010;
    localparam int SHORT_MAX = 32'h0000_001E;
    localparam int FALL = 32'h0000_0050;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic pushbutton_n = 1'b1;
    logic [15:0] fall_clocks = 16'h0000;
    logic poke = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, sleep_req, power_en, inv_en, power_on_alert_n;
    logic shutdown_alert_n, debounced_button_out_n;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    pwt_row_t rows [8] = '{
        '{1'b0, 32'h0000_0000, 32'h0000_0000, 32'(`PWT_RST_PERIOD)},
        '{1'b0, 32'h0000_0004, 32'h0000_0000, 32'(`PWT_RST_RANGE)},
        '{1'b0, 32'h0000_0008, 32'h0000_0000, 32'(`PWT_RST_LONG)},
        '{1'b0, 32'h0000_000C, 32'h0000_0000, 32'(`PWT_RST_MAXAWAKE)},
        '{1'b1, 32'h0000_0014, 32'hFFFF_FFFF, 32'h0000_0000},
        '{1'b0, 32'h0000_0014, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, 32'h0000_000C, 32'hFF00_001E, 32'h0000_0000},
        '{1'b0, 32'h0000_000C, 32'h0000_0000, 32'h0000_001E}
    };
    always #20 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    pwt_timer #(.TICK_CYCLES(TK), .EN_ACTIVE_LOW(1'b0)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pushbutton_n(pushbutton_n), .sleep_req(sleep_req),
        .run_at_powerup(1'b1), .power_en(power_en), .power_on_alert_n(power_on_alert_n),
        .shutdown_alert_n(shutdown_alert_n), .debounced_button_out_n(debounced_button_out_n));
    // same stimulus, inverted build: must mirror the main enable every cycle
    pwt_timer #(.TICK_CYCLES(TK), .EN_ACTIVE_LOW(1'b1)) u_dut_inv (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(), .hreadyout(),
        .hresp(), .pushbutton_n(pushbutton_n), .sleep_req(sleep_req), .run_at_powerup(1'b1),
        .power_en(inv_en), .power_on_alert_n(), .shutdown_alert_n(),
        .debounced_button_out_n());
    pwt_host_model u_host (.hclk(hclk), .hresetn(hresetn), .power_en(power_en),
        .fall_clocks(fall_clocks), .poke_in_sleep(poke), .sleep_req(sleep_req));

    task automatic tally_and_finish();
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input int e, input int tol, input logic [31:0] got);
        cmp_count++;
        if ((got + tol >= e) !== 1'b1 || (got <= e + tol) !== 1'b1) begin
            failures++;
            $display("unexpected %s: expected %0d, seen %0d", nm, e, got);
        end
    endtask : chk

    task automatic chk_bit(input string nm, input logic e, input logic got);
        cmp_count++;
        if (got !== e) begin
            failures++;
            $display("unexpected %s: expected %b, seen %b", nm, e, got);
        end
    endtask : chk_bit

    // bounded wait, sampled mid-cycle where registered outputs have settled
    task automatic wait_sig(input string nm, ref logic s, input logic v, input int bound);
        int n;
        n = 0;
        @(negedge hclk);
        while (s !== v) begin
            @(negedge hclk);
            n++;
            if (n > bound) begin
                failures++;
                $display("unexpected %s: expected %b, seen %b", nm, v, s);
                tally_and_finish();
            end
        end
    endtask : wait_sig

    // returns at the rising edge where hready is sampled high
    task automatic ready_edge();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                failures++;
                $display("unexpected hreadyout: expected 1, seen %b", hreadyout);
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask : ready_edge

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        ready_edge();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        ready_edge();
        rd = hrdata;
        chk_bit("hresp", 1'b0, hresp);
    endtask : ahb

    task automatic press(input logic v, input int hold);
        repeat (hold) @(posedge hclk);
        pushbutton_n <= v;
    endtask : press

    always @(negedge hclk) begin
        cmp_count++;
        if (inv_en !== ~power_en) begin
            failures++;
            $display("unexpected inv_en: expected %b, seen %b", ~power_en, inv_en);
        end
    end

    initial begin
        int t0;
        int t1;
        logic [31:0] rd;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wait_sig("power_en", power_en, 1'b1, 40);
        t0 = cyc;
        chk_bit("power_on_alert_n", 1'b0, power_on_alert_n);
        for (int i = 0; i < 8; i++) begin
            ahb(rows[i].w, rows[i].a, rows[i].d, rd);
            if (!rows[i].w) chk("hrdata", rows[i].e, 0, rd);
        end
        wait_sig("power_en", power_en, 1'b0, 400);
        chk("awake_len", SHORT_MAX * TK, SL, cyc - t0);
        ahb(1'b1, 32'h0000_000C, 32'(`PWT_RST_MAXAWAKE), rd);
        chk_bit("power_on_alert_n", 1'b1, power_on_alert_n);
        wait_sig("power_en", power_en, 1'b1, 1200);
        chk("period", `PWT_RST_PERIOD * TK, SL, cyc - t0);
        chk_bit("power_on_alert_n", 1'b1, power_on_alert_n);
        t0 = cyc;
        wait_sig("power_en", power_en, 1'b0, 400);
        chk("max_awake", `PWT_RST_MAXAWAKE * TK, SL, cyc - t0);
        // host decides on the enable edge whether to raise its pulse: set it while asleep
        fall_clocks <= 16'h000C;
        wait_sig("power_en", power_en, 1'b1, 1200);
        t0 = cyc;
        wait_sig("power_en", power_en, 1'b0, 400);
        chk("early_fall", `PWT_RST_MAXAWAKE * TK, SL, cyc - t0);
        fall_clocks <= 16'(FALL);
        wait_sig("power_en", power_en, 1'b1, 1200);
        t0 = cyc;
        poke <= 1'b1;
        wait_sig("power_en", power_en, 1'b0, 400);
        chk("sleep_fall", FALL, SL, cyc - t0);
        t1 = cyc;
        wait_sig("power_en", power_en, 1'b1, 700);
        chk("sleep_min", `PWT_SLEEP_MIN_MS * TK, SL, cyc - t1);
        poke <= 1'b0;
        wait_sig("power_en", power_en, 1'b0, 400);
        fall_clocks <= 16'h0000;
        press(1'b0, 560);
        wait_sig("debounced_button_out_n", debounced_button_out_n, 1'b0, 160);
        wait_sig("power_en", power_en, 1'b1, 10);
        t0 = cyc;
        press(1'b1, 150);
        wait_sig("debounced_button_out_n", debounced_button_out_n, 1'b1, 160);
        wait_sig("power_en", power_en, 1'b0, 1000);
        wait_sig("power_en", power_en, 1'b1, 1200);
        chk("press_period", `PWT_RST_PERIOD * TK, SL, cyc - t0);
        press(1'b0, 1);
        wait_sig("shutdown_alert_n", shutdown_alert_n, 1'b0, 800);
        chk_bit("power_en", 1'b1, power_en);
        t0 = cyc;
        wait_sig("shutdown_alert_n", shutdown_alert_n, 1'b1, 4200);
        chk("grace", `PWT_OFF_MS * TK, SL, cyc - t0);
        wait_sig("power_en", power_en, 1'b0, 10);
        press(1'b1, 1);
        t1 = 0;
        repeat (1500) @(negedge hclk) if (power_en !== 1'b0) t1++;
        chk("off_wakes", 0, 0, t1);
        press(1'b0, 1);
        wait_sig("power_en", power_en, 1'b1, 200);
        chk_bit("power_on_alert_n", 1'b0, power_on_alert_n);
        press(1'b1, 150);
        @(negedge hclk);
        chk_bit("power_on_alert_n", 1'b0, power_on_alert_n);
        wait_sig("power_en", power_en, 1'b0, 1000);
        repeat (2) @(negedge hclk);
        chk_bit("power_on_alert_n", 1'b1, power_on_alert_n);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
